// *** verilog/dsp_pkg.sv ***
// constants, types and carriers shared by the ddr sram port and its memory
// assumes a 36-bit data bus and an external address one bit below the word index, one word pair per address
package dsp_pkg;

    // ------------------------------------------------------------
    // widths and depths
    // ------------------------------------------------------------
    localparam int EXT_ADDR_W  = 19;
    localparam int INDEX_W     = EXT_ADDR_W + 1;
    localparam int DATA_W      = 36;
    localparam int PAIR_W      = 2 * DATA_W;
    localparam int MEM_DEPTH   = 1 << EXT_ADDR_W;
    localparam int FIFO_DEPTH  = 2;
    localparam int FIFO_CNT_W  = 2;

    // ------------------------------------------------------------
    // half select, burst and pipeline figures
    // ------------------------------------------------------------
    localparam logic HALF_FIRST  = 1'b0;
    localparam logic HALF_SECOND = 1'b1;
    localparam int   BURST_LEN   = 4;
    localparam int   READ_LAT    = 2;
    localparam int   DCD_CYCLES  = 2;
    localparam logic [FIFO_CNT_W-1:0] FIFO_FULL = 2'h2;
    localparam logic [FIFO_CNT_W-1:0] FIFO_NONE = 2'h0;
    localparam logic [FIFO_CNT_W-1:0] FIFO_ONE  = 2'h1;

    // ------------------------------------------------------------
    // clocks
    // ------------------------------------------------------------
    localparam int MCLK_PERIOD_NS = 50;
    localparam int LINK_PERIOD_NS = 30;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_IDLE  = 3'b001,
        OP_READ  = 3'b010,
        OP_WRITE = 3'b100
    } dsp_op_e;

    typedef struct packed {
        dsp_op_e               op;
        logic [EXT_ADDR_W-1:0] pair_addr;
    } dsp_cmd_s;

    typedef struct packed {
        logic [EXT_ADDR_W-1:0] pair_addr;
        logic [PAIR_W-1:0]     data;
    } dsp_wlog_s;

endpackage

// *** verilog/dsp_pair_mem.sv ***
// word-pair array of the sram port, one write and one registered read port
// assumes the caller resolves same-edge read/write collisions by forwarding
`timescale 1ns/1ps
`default_nettype none
module dsp_pair_mem (
    // clock and control
    input  wire logic                            clk_i,
    input  wire logic                            rst_i,
    input  wire logic                            ce_i,
    // write port
    input  wire logic                            we_i,
    input  wire logic [dsp_pkg::EXT_ADDR_W-1:0]  waddr_i,
    input  wire logic [dsp_pkg::PAIR_W-1:0]      wdata_i,
    // read port
    input  wire logic [dsp_pkg::EXT_ADDR_W-1:0]  raddr_i,
    output logic      [dsp_pkg::PAIR_W-1:0]      rdata_o
);

    logic [dsp_pkg::PAIR_W-1:0] mem [dsp_pkg::MEM_DEPTH];

    always_ff @(posedge clk_i) begin
        if (ce_i && we_i) begin
            mem[waddr_i] <= wdata_i;
        end
    end

    // read before write on a shared address
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_o <= '0;
        end else if (ce_i) begin
            rdata_o <= mem[raddr_i];
        end
    end

endmodule
`default_nettype wire

// *** verilog/dsp_sram_port.sv ***
// ddr synchronous sram port: late write, pipelined read, burst, echo clocks
// assumes link_clk_i is the controller's input clock; mclk_i side drains the write log
//
// Contract
// [RULE1] address and command sampled on rising edges
// [RULE2] writes self-timed, no external strobe needed
// [RULE3] ddr: data in and out, both edges
// [RULE4] half bit 0 first, 1 falling half
// [RULE5] external address one bit below index
// [RULE6] read data from rise/fall output registers
// [RULE7] outputs released two cycles after deselect
// [RULE8] late write: data follows command cycle
// [RULE9] read after pending write returns new data
// [RULE10] prog enables polarity set by straps
// [RULE11] echo clocks off when prog enable false
// [RULE12] optional burst for reads and writes
// [RULE13] controller loads address with step low
// [RULE14] active only with all three enables
// [RULE15] step high advances internal burst counter
// [RULE16] linear burst, wraps after four addresses
// [RULE17] controller gives beats rise then fall
// [RULE18] echo clocks track read data beats
`timescale 1ns/1ps
`default_nettype none
module dsp_sram_port (
    // system side
    input  wire logic                            mclk_i,
    input  wire logic                            rst_i,
    input  wire logic                            ce_i,
    // link clock and command
    input  wire logic                            link_clk_i,
    input  wire logic [dsp_pkg::EXT_ADDR_W-1:0]  addr_i,
    input  wire logic                            burst_step_select_i,
    input  wire logic                            write_n_i,
    input  wire logic                            chip_select_fixed_low_n_i,
    input  wire logic                            chip_select_prog_a_i,
    input  wire logic                            chip_select_prog_b_i,
    input  wire logic                            polarity_strap_a_i,
    input  wire logic                            polarity_strap_b_i,
    // link data and echo clocks
    input  wire logic [dsp_pkg::DATA_W-1:0]      data_i,
    output logic      [dsp_pkg::DATA_W-1:0]      data_o,
    output logic                                 data_oe_o,
    output logic                                 echo_clock_a_o,
    output logic                                 echo_clock_a_oe_o,
    output logic                                 echo_clock_b_o,
    output logic                                 echo_clock_b_oe_o,
    output logic                                 wlog_stall_o,
    // write log stream, system side
    output logic                                 wlog_valid_o,
    output dsp_pkg::dsp_wlog_s                   wlog_data_o,
    input  wire logic                            wlog_ready_i
);

    // ------------------------------------------------------------
    // link-side synchronisers
    // ------------------------------------------------------------
    logic ce_meta_reg, ce_link;
    logic pol_a_meta_reg, pol_a_reg, pol_b_meta_reg, pol_b_reg;
    logic ack_meta_reg, ack_sync_reg;
    logic ack_tgl_reg;

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ce_meta_reg    <= 1'b0;
            ce_link        <= 1'b0;
            pol_a_meta_reg <= 1'b0;
            pol_a_reg      <= 1'b0;
            pol_b_meta_reg <= 1'b0;
            pol_b_reg      <= 1'b0;
            ack_meta_reg   <= 1'b0;
            ack_sync_reg   <= 1'b0;
        end else begin
            ce_meta_reg    <= ce_i;
            ce_link        <= ce_meta_reg;
            pol_a_meta_reg <= polarity_strap_a_i;
            pol_a_reg      <= pol_a_meta_reg;
            pol_b_meta_reg <= polarity_strap_b_i;
            pol_b_reg      <= pol_b_meta_reg;
            ack_meta_reg   <= ack_tgl_reg;
            ack_sync_reg   <= ack_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // command decode and burst counter
    // ------------------------------------------------------------
    logic en_a, en_b, sel, e23;
    dsp_pkg::dsp_cmd_s            cmd_next, cmd_reg;
    dsp_pkg::dsp_op_e             burst_op_reg, burst_op_next;
    logic [dsp_pkg::EXT_ADDR_W-1:0] base_reg, base_next;
    logic                         step_reg, step_next;
    logic                         e23_reg, e23_d2_reg, adv_reg;

    assign en_a = (chip_select_prog_a_i == pol_a_reg);  // [RULE10]
    assign en_b = (chip_select_prog_b_i == pol_b_reg);  // [RULE10]
    assign e23  = en_a & en_b;
    assign sel  = ~chip_select_fixed_low_n_i & e23;     // [RULE14]

    always_comb begin
        cmd_next      = '{op: dsp_pkg::OP_IDLE, pair_addr: base_reg};
        burst_op_next = burst_op_reg;
        base_next     = base_reg;
        step_next     = step_reg;
        if (!sel) begin
            burst_op_next = dsp_pkg::OP_IDLE;           // [RULE14]
        end else if (!burst_step_select_i) begin
            // fresh load; the low half bit is never on the pins  [RULE5] [RULE13]
            cmd_next.op        = write_n_i ? dsp_pkg::OP_READ : dsp_pkg::OP_WRITE;
            cmd_next.pair_addr = addr_i;
            burst_op_next      = cmd_next.op;
            base_next          = addr_i;
            step_next          = 1'b0;
        end else begin
            // one-bit step over a pair index: four words then wrap  [RULE12] [RULE15] [RULE16]
            step_next          = ~step_reg;
            cmd_next.op        = burst_op_reg;
            cmd_next.pair_addr = {base_reg[dsp_pkg::EXT_ADDR_W-1:1], base_reg[0] ^ step_next};
        end
    end

    // sampled on the rising edge only  [RULE1]
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cmd_reg      <= '{op: dsp_pkg::OP_IDLE, pair_addr: '0};
            burst_op_reg <= dsp_pkg::OP_IDLE;
            base_reg     <= '0;
            step_reg     <= 1'b0;
            e23_reg      <= 1'b0;
            e23_d2_reg   <= 1'b0;
            adv_reg      <= 1'b0;
        end else if (ce_link) begin
            cmd_reg      <= cmd_next;
            burst_op_reg <= burst_op_next;
            base_reg     <= base_next;
            step_reg     <= step_next;
            e23_reg      <= e23;
            e23_d2_reg   <= e23_reg;
            adv_reg      <= sel & burst_step_select_i;
        end
    end

    // ------------------------------------------------------------
    // late write capture and commit
    // ------------------------------------------------------------
    logic                           wpend_v_reg;
    logic [dsp_pkg::EXT_ADDR_W-1:0] wpend_addr_reg;
    logic [dsp_pkg::DATA_W-1:0]     wlo_reg, whi_reg;
    logic                           mem_we;
    logic [dsp_pkg::PAIR_W-1:0]     mem_wdata, mem_rdata;

    // beat 0 on the rise after the command cycle  [RULE8] [RULE17]
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            wpend_v_reg    <= 1'b0;
            wpend_addr_reg <= '0;
            wlo_reg        <= '0;
        end else if (ce_link) begin
            wpend_v_reg    <= (cmd_reg.op == dsp_pkg::OP_WRITE);
            wpend_addr_reg <= cmd_reg.pair_addr;
            if (cmd_reg.op == dsp_pkg::OP_WRITE) begin
                wlo_reg <= data_i;
            end
        end
    end

    // second half on the falling edge  [RULE3] [RULE4]
    always_ff @(negedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            whi_reg <= '0;
        end else if (ce_link && wpend_v_reg) begin
            whi_reg <= data_i;
        end
    end

    // internal write pulse, no strobe from the pins  [RULE2]
    assign mem_we    = wpend_v_reg & ce_link;
    assign mem_wdata = {whi_reg, wlo_reg};

    dsp_pair_mem u_mem (
        .clk_i   (link_clk_i),
        .rst_i   (rst_i),
        .ce_i    (ce_link),
        .we_i    (mem_we),
        .waddr_i (wpend_addr_reg),
        .wdata_i (mem_wdata),
        .raddr_i (cmd_reg.pair_addr),
        .rdata_o (mem_rdata)
    );

    // ------------------------------------------------------------
    // read pipeline, forwarding and ddr output
    // ------------------------------------------------------------
    logic                       rd_v2_reg, hit2_reg, oe_reg;
    logic [dsp_pkg::PAIR_W-1:0] fwd2_reg, word2;
    logic [dsp_pkg::DATA_W-1:0] q_rise_reg, q_fall_reg, hi_hold_reg, lo_chk_reg;
    logic                       eq_rise_reg, eq_fall_reg, echo_oe_reg;

    function automatic logic [dsp_pkg::DATA_W-1:0] half_of(input logic [dsp_pkg::PAIR_W-1:0] w, input logic h);
        half_of = h ? w[dsp_pkg::PAIR_W-1:dsp_pkg::DATA_W] : w[dsp_pkg::DATA_W-1:0];
    endfunction

    // the write committing on this edge is invisible to the array read  [RULE9]
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_v2_reg <= 1'b0;
            hit2_reg  <= 1'b0;
            fwd2_reg  <= '0;
        end else if (ce_link) begin
            rd_v2_reg <= (cmd_reg.op == dsp_pkg::OP_READ);
            hit2_reg  <= (cmd_reg.op == dsp_pkg::OP_READ) && wpend_v_reg
                         && (wpend_addr_reg == cmd_reg.pair_addr);
            fwd2_reg  <= {whi_reg, wlo_reg};
        end
    end

    // idle slots feed zeros: an unwritten word would stick in the xor pair for good
    assign word2 = hit2_reg ? fwd2_reg : (rd_v2_reg ? mem_rdata : '0);

    // xor pair avoids muxing on the clock itself  [RULE6] [RULE4]
    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_rise_reg  <= '0;
            hi_hold_reg <= '0;
            lo_chk_reg  <= '0;
            oe_reg      <= 1'b0;
            eq_rise_reg <= 1'b0;
            echo_oe_reg <= 1'b0;
        end else if (ce_link) begin
            q_rise_reg  <= half_of(word2, dsp_pkg::HALF_FIRST) ^ q_fall_reg;
            hi_hold_reg <= half_of(word2, dsp_pkg::HALF_SECOND);
            lo_chk_reg  <= half_of(word2, dsp_pkg::HALF_FIRST);
            oe_reg      <= rd_v2_reg;                    // [RULE7]
            eq_rise_reg <= ~eq_fall_reg;                 // [RULE18]
            echo_oe_reg <= e23_d2_reg;                   // [RULE11]
        end
    end

    always_ff @(negedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            q_fall_reg  <= '0;
            eq_fall_reg <= 1'b0;
        end else if (ce_link) begin
            q_fall_reg  <= hi_hold_reg ^ q_rise_reg;     // [RULE3]
            eq_fall_reg <= eq_rise_reg;                  // [RULE18]
        end
    end

    assign data_o            = q_rise_reg ^ q_fall_reg;
    assign data_oe_o         = oe_reg;
    assign echo_clock_a_o    = eq_rise_reg ^ eq_fall_reg;
    assign echo_clock_b_o    = eq_rise_reg ^ eq_fall_reg;
    assign echo_clock_a_oe_o = echo_oe_reg;
    assign echo_clock_b_oe_o = echo_oe_reg;

    // ------------------------------------------------------------
    // write log crossing, link side
    // ------------------------------------------------------------
    logic               req_tgl_reg, log_busy, stall_reg;
    dsp_pkg::dsp_wlog_s log_word_reg;

    // the sram cannot stall its controller, so a full log is flagged instead
    assign log_busy = req_tgl_reg ^ ack_sync_reg;

    always_ff @(posedge link_clk_i or posedge rst_i) begin
        if (rst_i) begin
            req_tgl_reg  <= 1'b0;
            log_word_reg <= '0;
            stall_reg    <= 1'b0;
        end else if (ce_link) begin
            stall_reg <= mem_we & log_busy;
            if (mem_we && !log_busy) begin
                log_word_reg <= '{pair_addr: wpend_addr_reg, data: mem_wdata};
                req_tgl_reg  <= ~req_tgl_reg;
            end
        end
    end

    assign wlog_stall_o = stall_reg;

    // ------------------------------------------------------------
    // write log crossing and two-entry buffer, system side
    // ------------------------------------------------------------
    logic                               req_meta_reg, req_sync_reg, pending, push, pop, fifo_ready;
    logic [dsp_pkg::FIFO_CNT_W-1:0]     cnt_reg;
    logic                               wptr_reg, rptr_reg;
    dsp_pkg::dsp_wlog_s                 fifo_reg [dsp_pkg::FIFO_DEPTH];

    assign pending    = req_sync_reg ^ ack_tgl_reg;
    assign fifo_ready = (cnt_reg != dsp_pkg::FIFO_FULL);
    assign push       = ce_i & pending & fifo_ready;
    assign pop        = ce_i & wlog_valid_o & wlog_ready_i;

    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
        end else begin
            req_meta_reg <= req_tgl_reg;
            req_sync_reg <= req_meta_reg;
        end
    end

    // word held stable by the link until this toggle returns
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            ack_tgl_reg <= 1'b0;
            wptr_reg    <= 1'b0;
            rptr_reg    <= 1'b0;
            cnt_reg     <= dsp_pkg::FIFO_NONE;
        end else begin
            if (push) begin
                ack_tgl_reg <= ~ack_tgl_reg;
                wptr_reg    <= ~wptr_reg;
            end
            if (pop) begin
                rptr_reg <= ~rptr_reg;
            end
            if (push && !pop) begin
                cnt_reg <= cnt_reg + dsp_pkg::FIFO_ONE;
            end else if (pop && !push) begin
                cnt_reg <= cnt_reg - dsp_pkg::FIFO_ONE;
            end
        end
    end

    always_ff @(posedge mclk_i) begin
        if (push) begin
            fifo_reg[wptr_reg] <= log_word_reg;
        end
    end

    assign wlog_valid_o = (cnt_reg != dsp_pkg::FIFO_NONE);
    assign wlog_data_o  = wlog_valid_o ? fifo_reg[rptr_reg] : '0;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    chk_read_latency: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE6]
        ce_link && cmd_reg.op == dsp_pkg::OP_READ ##1 ce_link |=> data_oe_o)
        else $error("read data not driven two cycles after command");
    chk_dcd_release: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE7]
        ce_link && cmd_reg.op != dsp_pkg::OP_READ ##1 ce_link |=> !data_oe_o)
        else $error("outputs not released two cycles after non-read");
    chk_late_commit: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE8]
        ce_link && cmd_reg.op == dsp_pkg::OP_WRITE |=> mem_we || !ce_link)
        else $error("write not committed one cycle after command");
    chk_write_pair: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE17]
        mem_we |-> mem_wdata[dsp_pkg::DATA_W-1:0] == $past(data_i))
        else $error("first write beat not taken on rising edge");
    chk_coherent_fwd: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE9]
        ce_link && cmd_reg.op == dsp_pkg::OP_READ && wpend_v_reg
        && wpend_addr_reg == cmd_reg.pair_addr |=> hit2_reg && word2 == $past(mem_wdata))
        else $error("read after pending write missed new data");
    chk_burst_wrap: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE16]
        ce_link && !adv_reg && cmd_reg.op != dsp_pkg::OP_IDLE ##1 (ce_link && adv_reg) [*2]
        |-> cmd_reg.pair_addr == $past(cmd_reg.pair_addr, 2))
        else $error("burst counter did not wrap after four addresses");
    chk_burst_step: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE15]
        ce_link && adv_reg && $past(cmd_reg.op) != dsp_pkg::OP_IDLE && $past(ce_link)
        |-> cmd_reg.pair_addr[0] != $past(cmd_reg.pair_addr[0]))
        else $error("burst step did not advance the counter");
    chk_enable_all: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE14]
        $past(ce_link) && !$past(adv_reg) && cmd_reg.op != dsp_pkg::OP_IDLE
        |-> !$past(chip_select_fixed_low_n_i) && $past(chip_select_prog_a_i) == $past(pol_a_reg)
        && $past(chip_select_prog_b_i) == $past(pol_b_reg))
        else $error("access started without all enables");
    chk_echo_gate: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE11]
        ce_link && !e23 ##1 ce_link ##1 ce_link |=> !echo_clock_a_oe_o)
        else $error("echo clock driven after prog enable false");
    chk_rise_beat: assert property (@(negedge link_clk_i) disable iff (rst_i) // [RULE3]
        data_oe_o |-> data_o == lo_chk_reg)
        else $error("rising beat not the first half");
    chk_fall_beat: assert property (@(posedge link_clk_i) disable iff (rst_i) // [RULE4]
        ce_link && rd_v2_reg ##1 ce_link |-> data_o == hi_hold_reg)
        else $error("falling beat not the second half");
    chk_log_full: assert property (@(posedge mclk_i) disable iff (rst_i)
        cnt_reg == dsp_pkg::FIFO_FULL && !pop |=> cnt_reg == dsp_pkg::FIFO_FULL)
        else $error("log buffer lost an entry");

    cov_read: cover property (@(posedge link_clk_i) disable iff (rst_i) data_oe_o && echo_clock_a_oe_o);
    cov_write: cover property (@(posedge link_clk_i) disable iff (rst_i) mem_we);
    cov_burst: cover property (@(posedge link_clk_i) disable iff (rst_i) adv_reg [*2]);
    cov_forward: cover property (@(posedge link_clk_i) disable iff (rst_i) hit2_reg);
    cov_log_full: cover property (@(posedge mclk_i) disable iff (rst_i) !fifo_ready);

endmodule
`default_nettype wire

// *** testbench/dsp_ctl_model.sv ***
// memory controller model: commands on link rises, late-write beats rise then fall
// assumes the bench calls issue once per link rise; idle data shows inverted last value
`timescale 1ns/1ps
`default_nettype none
module dsp_ctl_model (
    // link clock
    input  wire logic                           link_clk_i,
    // command and data toward the port
    output logic      [dsp_pkg::EXT_ADDR_W-1:0] addr_o,
    output logic                                step_o,
    output logic                                write_n_o,
    output logic      [2:0]                     en_o,
    output logic      [dsp_pkg::DATA_W-1:0]     data_o
);
    logic                       wr_pend;
    logic                       hi_pend;
    logic [dsp_pkg::PAIR_W-1:0] wd_pend;
    logic [dsp_pkg::DATA_W-1:0] wd_hi;
    logic [dsp_pkg::DATA_W-1:0] wd_lo;

    initial begin
        {addr_o, step_o, data_o, wr_pend, hi_pend} = '0;
        write_n_o = 1'b1;
        en_o      = 3'b100;
    end

    // en is {fixed low enable, prog a, prog b}; step low loads a fresh address
    task automatic issue(input logic wr, input logic st, input logic [2:0] en,
                         input logic [dsp_pkg::EXT_ADDR_W-1:0] a, input logic [dsp_pkg::PAIR_W-1:0] d);
        @(posedge link_clk_i);
        addr_o    <= a;
        step_o    <= st;
        write_n_o <= ~wr;
        en_o      <= en;
        wr_pend   <= wr;
        wd_pend   <= d;
    endtask

    // beat0 set on the fall before the rise that takes it, beat1 set on that rise
    always @(posedge link_clk_i) begin
        data_o  <= hi_pend ? wd_hi : ~data_o;
        hi_pend <= wr_pend;
        wd_lo   <= wd_pend[35:0];
        wd_hi   <= wd_pend[71:36];
    end
    always @(negedge link_clk_i) begin
        data_o <= hi_pend ? wd_lo : ~data_o;
    end
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench of the ddr sram port against a controller model
// assumes free-running 50 ns system clock and 30 ns link clock, unrelated phase
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb_top;
    localparam logic [18:0] A  = 19'h1_2344;
    localparam logic [18:0] B  = 19'h0_0a10;
    localparam logic [71:0] D0 = 72'h11_1111_1111_2222_2222;
    localparam logic [71:0] D1 = 72'h33_3333_3333_4444_4444;
    localparam logic [71:0] E0 = 72'h55_5555_5555_6666_6666;
    localparam logic [71:0] E1 = 72'h77_7777_7777_8888_8888;
    logic mclk, link_clk, rst, ce, ready, strap_a, strap_b, step, wr_n, oe, eca, eoa, ecb, eob, stall, valid;
    logic [1:0] pg;
    logic [2:0] en;
    logic [18:0] addr;
    logic [35:0] din, dout;
    dsp_pkg::dsp_wlog_s wlog;
    int n_fail, compares, n_stall;

    dsp_ctl_model dsp_ctl_model_i (.link_clk_i(link_clk), .addr_o(addr), .step_o(step), .write_n_o(wr_n),
        .en_o(en), .data_o(din));
    dsp_sram_port dsp_sram_port_i (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .link_clk_i(link_clk),
        .addr_i(addr), .burst_step_select_i(step), .write_n_i(wr_n), .chip_select_fixed_low_n_i(en[2]),
        .chip_select_prog_a_i(en[1]), .chip_select_prog_b_i(en[0]), .polarity_strap_a_i(strap_a),
        .polarity_strap_b_i(strap_b), .data_i(din), .data_o(dout), .data_oe_o(oe), .echo_clock_a_o(eca),
        .echo_clock_a_oe_o(eoa), .echo_clock_b_o(ecb), .echo_clock_b_oe_o(eob), .wlog_stall_o(stall),
        .wlog_valid_o(valid), .wlog_data_o(wlog), .wlog_ready_i(ready));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic cmd(input logic wr, input logic st, input logic [18:0] a, input logic [71:0] d);
        dsp_ctl_model_i.issue(wr, st, {1'b0, pg}, a, d);
    endtask
    task automatic nop(input int n);
        repeat (n) dsp_ctl_model_i.issue(1'b0, 1'b0, {1'b1, pg}, 19'h7_ffff, '0);
    endtask
    task automatic chk_pair(input logic [71:0] e);
        #1;
        `CHK("oe", 1'b1, oe)
        `CHK("beat0", e[35:0], dout)
        `CHK("echo_rise", 1'b1, eca)
        `CHK("echo_b_rise", 1'b1, ecb)
        @(negedge link_clk);
        #1;
        `CHK("beat1", e[71:36], dout)
        `CHK("echo_fall", 1'b0, eca)
    endtask
    task automatic pop();
        @(posedge mclk);
        ready <= 1'b1;
        @(posedge mclk);
        ready <= 1'b0;
        #1;
    endtask
    task automatic finish_test();
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_write_log();
        cmd(1'b1, 1'b0, A, D0);
        nop(10);
        cmd(1'b1, 1'b0, A ^ 19'h0_0001, D1);
        nop(10);
        `CHK("log0", {A, D0}, wlog)
        pop();
        `CHK("log1", {A ^ 19'h0_0001, D1}, wlog)
        pop();
        `CHK("log_empty", 1'b0, valid)
    endtask
    task automatic t_burst_read();
        cmd(1'b0, 1'b0, A, '0);
        cmd(1'b0, 1'b1, A, '0);
        cmd(1'b0, 1'b1, A, '0);
        nop(1);
        chk_pair(D0);
        nop(1);
        chk_pair(D1);
        nop(1);
        chk_pair(D0);
        nop(1);
        #1;
        `CHK("oe_release", 1'b0, oe)
    endtask
    task automatic t_coherent();
        cmd(1'b1, 1'b0, B, E0);
        cmd(1'b1, 1'b1, B, E1);
        cmd(1'b0, 1'b0, B ^ 19'h0_0001, '0);
        cmd(1'b0, 1'b0, B, '0);
        nop(2);
        chk_pair(E1);
        nop(1);
        chk_pair(E0);
        nop(2);
    endtask
    task automatic t_fill();
        n_stall = 0;
        cmd(1'b1, 1'b0, 19'h0_0100, D1);
        repeat (3) cmd(1'b1, 1'b1, 19'h0_0100, D0);
        nop(20);
        `CHK("stall_seen", 1'b1, n_stall > 0)
        for (int i = 0; i < 8 && valid === 1'b1; i++) pop();
        `CHK("drained", 1'b0, valid)
    endtask
    task automatic t_enables();
        dsp_ctl_model_i.issue(1'b0, 1'b0, 3'b001, B, '0);
        nop(3);
        #1;
        `CHK("echo_off", 1'b0, eoa)
        `CHK("echo_b_off", 1'b0, eob)
        `CHK("desel_oe", 1'b0, oe)
        nop(2);
        #1;
        `CHK("echo_on", 1'b1, eoa)
        @(posedge link_clk);
        strap_a <= 1'b0;
        strap_b <= 1'b0;
        pg = 2'b00;
        nop(4);
        cmd(1'b0, 1'b0, B, '0);
        nop(3);
        chk_pair(E0);
    endtask

    always @(posedge link_clk) begin
        if (stall === 1'b1) n_stall++;
    end
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    initial begin
        link_clk = 1'b0;
        #7;
        forever #15 link_clk = ~link_clk;
    end
    initial begin
        #200us;
        n_fail++;
        finish_test();
    end
    initial begin
        {n_fail, compares, n_stall} = '0;
        {rst, ce, ready, strap_a, strap_b, pg} = 7'b1_1011_11;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        nop(4);
        t_write_log();
        t_burst_read();
        t_coherent();
        t_fill();
        t_enables();
        finish_test();
    end
endmodule
`default_nettype wire
